// File: hdl/cpom_params.svh
// Constants of the controller pulse output modulator
`ifndef CPOM_PARAMS_SVH
`define CPOM_PARAMS_SVH
// Value range of source and bounds
`define CPOM_VAL_MAX        14'h270f
// Time settings are in tenths of a second
`define CPOM_CYCLE_MAX      14'h2706
`define CPOM_CYCLE_DEF      14'h0064
`define CPOM_MINON_MIN      14'h0003
`define CPOM_MINON_DEF      14'h0003
// Pulse frequency in pulses per minute
`define CPOM_FREQ_MIN       8'h01
`define CPOM_FREQ_MAX       8'hb4
`define CPOM_FREQ_DEF       8'h3c
// One tenth second at 200 MHz, in ns and in cycles
`define CPOM_TICK_NS        100000000
`define CPOM_CLK_NS         5
`define CPOM_TICK_CYC       (`CPOM_TICK_NS / `CPOM_CLK_NS)
// Tenths per minute
`define CPOM_TENTHS_MIN     14'h0258
// Pulse width in pulse frequency mode is half the shortest period
`define CPOM_PFM_DIV        2
`endif

// File: hdl/cpom_pkg.sv
// Types of the controller pulse output modulator
`default_nettype none
package cpom_pkg;
  typedef enum logic [0:0] {CPOM_PWM = 1'b0, CPOM_PFM = 1'b1} cpom_mode_t;
  typedef enum logic [1:0] {CPOM_HOLD_IGNORE = 2'h0, CPOM_HOLD_FREEZE = 2'h1,
                            CPOM_HOLD_FIXED = 2'h2} cpom_hold_t;
  typedef enum logic [1:0] {CPOM_ST_OFF = 2'h0, CPOM_ST_ON = 2'h1} cpom_state_t;
endpackage
`default_nettype wire

// File: hdl/cpom_tick.sv
// Divider that makes a tenth-second tick from the 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "cpom_params.svh"
module cpom_tick #(
  parameter int unsigned TICK_CYC = `CPOM_TICK_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  output logic      o_tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  // Count down and pulse once per period
  always_comb
  begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg - 32'h1;
    if (cnt_reg == 32'h0)
    begin
      cnt_next  = TICK_CYC - 32'h1;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;
endmodule
`default_nettype wire

// File: hdl/cpom_top.sv
// Controller pulse output modulator: PWM or PFM drive of a binary output
// ---------------------------------------------------------------------
// What this block does
// - Two modes, PWM default after reset
// - Scale source between bounded lower, upper limits
// - PWM duty in cycle up to 999.0s
// - Cycle duration never below shortest on-time
// - Suppress PWM pulses shorter than minimum on-time
// - PFM rate capped 1..180/min, sets pulse length
// - Freeze really holds the output state
// - PFM pulse train runs continuously on output, no pulses at zero fraction
// - Hold: freeze, fixed value, or ignore default
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "cpom_params.svh"
module cpom_top #(
  parameter int unsigned TICK_CYC = `CPOM_TICK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cfg_load,
  input  wire logic        i_cfg_mode_pfm,
  input  wire logic [13:0] i_cfg_range_lo,
  input  wire logic [13:0] i_cfg_range_hi,
  input  wire logic [13:0] i_cfg_cycle,
  input  wire logic [13:0] i_cfg_min_on,
  input  wire logic [7:0]  i_cfg_max_freq,
  input  wire logic [1:0]  i_cfg_hold_mode,
  input  wire logic [13:0] i_source,
  input  wire logic        i_hold,
  input  wire logic [13:0] i_hold_fixed,
  output logic             o_pulse,
  output logic             o_mode_pfm,
  output logic [13:0]      o_range_lo,
  output logic [13:0]      o_range_hi,
  output logic [13:0]      o_cycle,
  output logic [13:0]      o_min_on,
  output logic [7:0]       o_max_freq,
  output logic [1:0]       o_hold_mode
);
  // ---------------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------------
  cpom_pkg::cpom_mode_t mode_reg, mode_next;
  cpom_pkg::cpom_hold_t hold_reg, hold_next;
  logic [13:0] lo_reg, lo_next, hi_reg, hi_next;
  logic [13:0] cyc_reg, cyc_next, mon_reg, mon_next;
  logic [7:0]  frq_reg, frq_next;

  // Clamp every setting into its legal window on load
  always_comb
  begin
    mode_next = mode_reg;
    hold_next = hold_reg;
    lo_next   = lo_reg;
    hi_next   = hi_reg;
    cyc_next  = cyc_reg;
    mon_next  = mon_reg;
    frq_next  = frq_reg;
    if (i_cfg_load)
    begin
      mode_next = i_cfg_mode_pfm ? cpom_pkg::CPOM_PFM : cpom_pkg::CPOM_PWM;
      unique case (i_cfg_hold_mode)
        2'h1:    hold_next = cpom_pkg::CPOM_HOLD_FREEZE;
        2'h2:    hold_next = cpom_pkg::CPOM_HOLD_FIXED;
        default: hold_next = cpom_pkg::CPOM_HOLD_IGNORE;
      endcase
      lo_next = (i_cfg_range_lo > `CPOM_VAL_MAX) ? `CPOM_VAL_MAX : i_cfg_range_lo;
      hi_next = (i_cfg_range_hi > `CPOM_VAL_MAX) ? `CPOM_VAL_MAX : i_cfg_range_hi;
      if (hi_next < lo_next)
        hi_next = lo_next;
      mon_next = (i_cfg_min_on < `CPOM_MINON_MIN) ? `CPOM_MINON_MIN : i_cfg_min_on;
      cyc_next = (i_cfg_cycle > `CPOM_CYCLE_MAX) ? `CPOM_CYCLE_MAX : i_cfg_cycle;
      // The on-time limit yields to the cycle; a cycle below the on-time floor is raised to it
      if (mon_next > cyc_next)
        mon_next = cyc_next;
      if (cyc_next < `CPOM_MINON_MIN)
      begin
        cyc_next = `CPOM_MINON_MIN;
        mon_next = `CPOM_MINON_MIN;
      end
      frq_next = (i_cfg_max_freq < `CPOM_FREQ_MIN) ? `CPOM_FREQ_MIN :
                 (i_cfg_max_freq > `CPOM_FREQ_MAX) ? `CPOM_FREQ_MAX : i_cfg_max_freq;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      mode_reg <= cpom_pkg::CPOM_PWM;
      hold_reg <= cpom_pkg::CPOM_HOLD_IGNORE;
      lo_reg   <= 14'h0000;
      hi_reg   <= `CPOM_VAL_MAX;
      cyc_reg  <= `CPOM_CYCLE_DEF;
      mon_reg  <= `CPOM_MINON_DEF;
      frq_reg  <= `CPOM_FREQ_DEF;
    end
    else
    begin
      mode_reg <= mode_next;
      hold_reg <= hold_next;
      lo_reg   <= lo_next;
      hi_reg   <= hi_next;
      cyc_reg  <= cyc_next;
      mon_reg  <= mon_next;
      frq_reg  <= frq_next;
    end
  end

  // ---------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------
  logic tick;

  cpom_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .o_tick   (tick)
  );

  // ---------------------------------------------------------------------
  // Scaling: position of source in range as fraction of 2^14
  // ---------------------------------------------------------------------
  logic [13:0] src_eff;
  logic [13:0] span;
  logic [13:0] pos;
  logic [27:0] frac_w;
  logic [13:0] frac;

  // Division once per period is cheap in area terms only at this slow rate
  always_comb
  begin
    // Fixed hold swaps in the user value; ignore and freeze pass the source on
    src_eff = i_source;
    if (i_hold && hold_reg == cpom_pkg::CPOM_HOLD_FIXED)
      src_eff = i_hold_fixed;
    span    = hi_reg - lo_reg;
    if (src_eff <= lo_reg)
      pos = 14'h0000;
    else if (src_eff >= hi_reg)
      pos = span;
    else
      pos = src_eff - lo_reg;
    frac_w = (span == 14'h0000) ? 28'h0 : ({pos, 14'h0000} / {14'h0000, span});
    frac   = (frac_w[14]) ? 14'h3fff : frac_w[13:0];
  end

  // ---------------------------------------------------------------------
  // Pulse generator
  // ---------------------------------------------------------------------
  cpom_pkg::cpom_state_t st_reg, st_next;
  logic [13:0] per_reg, per_next;   // Tenths elapsed in current period
  logic [13:0] on_reg, on_next;     // On-time of current period
  logic [13:0] len_reg, len_next;   // Length of current period
  logic        out_reg, out_next;
  logic [27:0] prod;
  logic [13:0] on_calc;
  logic [13:0] pfm_min_per;
  logic [13:0] pfm_per;
  logic [27:0] pfm_q;
  logic        freeze;

  always_comb
  begin
    freeze   = i_hold && (hold_reg == cpom_pkg::CPOM_HOLD_FREEZE);
    st_next  = st_reg;
    per_next = per_reg;
    on_next  = on_reg;
    len_next = len_reg;
    out_next = out_reg;
    prod     = 28'h0;
    on_calc  = 14'h0000;
    // Shortest PFM period in tenths; pulse is half of it
    pfm_min_per = 14'(`CPOM_TENTHS_MIN / {6'h00, frq_reg});
    // Period grows as the fraction shrinks; zero fraction means no pulses
    pfm_q   = (frac == 14'h0000) ? 28'h3fff :
              (({14'h0000, pfm_min_per} << 14) / {14'h0000, frac});
    // Saturate so a tiny fraction gives the slowest rate, not a wrapped fast one
    pfm_per = (pfm_q > 28'h3fff) ? 14'h3fff : pfm_q[13:0];
    if (tick && !freeze)
    begin
      per_next = per_reg + 14'h0001;
      if (per_reg + 14'h0001 >= len_reg)
      begin
        // Start of a new period: latch its on-time and length
        per_next = 14'h0000;
        if (mode_reg == cpom_pkg::CPOM_PWM)
        begin
          prod    = {14'h0000, cyc_reg} * {14'h0000, frac};
          on_calc = prod[27:14];
          if (on_calc < mon_reg)
            on_calc = 14'h0000;
          len_next = cyc_reg;
        end
        else
        begin
          on_calc  = (frac == 14'h0000) ? 14'h0000 : 14'(pfm_min_per / `CPOM_PFM_DIV);
          if (on_calc == 14'h0000 && frac != 14'h0000)
            on_calc = 14'h0001;
          len_next = (pfm_per < pfm_min_per) ? pfm_min_per : pfm_per;
        end
        on_next = on_calc;
      end
      unique case (st_reg)
        cpom_pkg::CPOM_ST_OFF: if (per_next < on_next) st_next = cpom_pkg::CPOM_ST_ON;
        cpom_pkg::CPOM_ST_ON:  if (per_next >= on_next) st_next = cpom_pkg::CPOM_ST_OFF;
        default:               st_next = cpom_pkg::CPOM_ST_OFF;
      endcase
      out_next = (st_next == cpom_pkg::CPOM_ST_ON);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      st_reg  <= cpom_pkg::CPOM_ST_OFF;
      per_reg <= 14'h0000;
      on_reg  <= 14'h0000;
      len_reg <= 14'h0001;
      out_reg <= 1'b0;
    end
    else
    begin
      st_reg  <= st_next;
      per_reg <= per_next;
      on_reg  <= on_next;
      len_reg <= len_next;
      out_reg <= out_next;
    end
  end

  // Outputs come straight from registers
  assign o_pulse     = out_reg;
  assign o_mode_pfm  = (mode_reg == cpom_pkg::CPOM_PFM);
  assign o_range_lo  = lo_reg;
  assign o_range_hi  = hi_reg;
  assign o_cycle     = cyc_reg;
  assign o_min_on    = mon_reg;
  assign o_max_freq  = frq_reg;
  assign o_hold_mode = hold_reg;
endmodule
`default_nettype wire

// File: verif/cpom_checker.sv
// Port checks of the pulse output modulator
`timescale 1ns/1ps
`default_nettype none
`include "cpom_params.svh"
module cpom_checker #(
  parameter int unsigned TICK_CYC = `CPOM_TICK_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_cfg_load,
  input wire logic        i_cfg_mode_pfm,
  input wire logic [1:0]  i_cfg_hold_mode,
  input wire logic        i_hold,
  input wire logic        o_pulse,
  input wire logic        o_mode_pfm,
  input wire logic [13:0] o_range_lo,
  input wire logic [13:0] o_range_hi,
  input wire logic [13:0] o_cycle,
  input wire logic [13:0] o_min_on,
  input wire logic [7:0]  o_max_freq,
  input wire logic [1:0]  o_hold_mode
);
  logic [31:0] run_reg;
  logic [31:0] run_next;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Length of the current high run; a reset mid-run discards it
  always_comb run_next = o_pulse ? run_reg + 32'h1 : 32'h0;
  always_ff @(posedge i_clk) run_reg <= i_resetn ? run_next : 32'h0;
  sequence cfg_take;
    i_cfg_load && i_cfg_hold_mode != 2'h3;
  endsequence
  sequence pwm_end;
    $fell(o_pulse) && !o_mode_pfm;
  endsequence
  reset_value_a: assert property (disable iff (1'b0) !i_resetn |=> !o_pulse && !o_mode_pfm
    && o_range_lo == 14'h0 && o_range_hi == `CPOM_VAL_MAX && o_cycle == `CPOM_CYCLE_DEF
    && o_min_on == `CPOM_MINON_DEF && o_max_freq == `CPOM_FREQ_DEF && o_hold_mode == 2'h0)
    else $error("reset value wrong");
  range_order_a: assert property (o_range_lo <= o_range_hi && o_range_hi <= `CPOM_VAL_MAX)
    else $error("range bounds wrong");
  cycle_floor_a: assert property (o_min_on <= o_cycle && o_cycle <= `CPOM_CYCLE_MAX
    && o_min_on >= `CPOM_MINON_MIN) else $error("cycle or min on wrong");
  freq_bound_a: assert property (o_max_freq >= `CPOM_FREQ_MIN
    && o_max_freq <= `CPOM_FREQ_MAX) else $error("max frequency wrong");
  load_mode_a: assert property (cfg_take |=> o_mode_pfm == $past(i_cfg_mode_pfm)
    && o_hold_mode == $past(i_cfg_hold_mode)) else $error("mode not taken");
  cfg_keep_a: assert property (!i_cfg_load |=> $stable({o_mode_pfm, o_range_lo, o_range_hi,
    o_cycle, o_min_on, o_max_freq, o_hold_mode})) else $error("config moved");
  freeze_keep_a: assert property (i_hold && $past(i_hold)
    && o_hold_mode == cpom_pkg::CPOM_HOLD_FREEZE |=> $stable(o_pulse)) else $error("not frozen");
  min_run_a: assert property (pwm_end |-> run_reg >= o_min_on * TICK_CYC)
    else $error("short pulse output");
endmodule
bind cpom_top cpom_checker #(.TICK_CYC(TICK_CYC)) chk (.i_clk, .i_resetn, .i_cfg_load,
  .i_cfg_mode_pfm, .i_cfg_hold_mode, .i_hold, .o_pulse, .o_mode_pfm, .o_range_lo,
  .o_range_hi, .o_cycle, .o_min_on, .o_max_freq, .o_hold_mode);
`default_nettype wire

// File: verif/cpom_pump_model.sv
// Dosing pump model: counts strokes, stroke length and stroke spacing
`timescale 1ns/1ps
`default_nettype none
module cpom_pump_model (
  input  wire logic i_clk,
  input  wire logic i_drive,
  output int        o_strokes,
  output int        o_on_cyc,
  output int        o_period_cyc
);
  int   on_run = 0;
  int   per_run = 0;
  logic prev = 1'b0;
  initial {o_strokes, o_on_cyc, o_period_cyc} = '0;
  // A stroke starts on each rising drive; lengths are in clocks
  always @(posedge i_clk)
  begin
    per_run <= per_run + 1;
    on_run <= i_drive ? on_run + 1 : 0;
    if (i_drive && !prev)
    begin
      o_strokes <= o_strokes + 1;
      o_period_cyc <= per_run;
      per_run <= 1;
    end
    if (!i_drive && prev) o_on_cyc <= on_run;
    prev <= i_drive;
  end
endmodule
`default_nettype wire

// File: verif/cpom_top_tb.sv
// Self-checking bench of the pulse output modulator
`timescale 1ns/1ps
`default_nettype none
module cpom_top_tb;
  localparam int TICK = 10;
  logic i_clk, i_resetn, i_cfg_load, i_cfg_mode_pfm, i_hold, o_pulse, o_mode_pfm;
  logic [13:0] i_cfg_range_lo, i_cfg_range_hi, i_cfg_cycle, i_cfg_min_on, i_source;
  logic [13:0] i_hold_fixed, o_range_lo, o_range_hi, o_cycle, o_min_on;
  logic [7:0]  i_cfg_max_freq, o_max_freq;
  logic [1:0]  i_cfg_hold_mode, o_hold_mode;
  int          strokes, on_cyc, period_cyc, s, bad_count = 0, check_count = 0;
  // Hold cases: freeze, fixed, ignore, spare code; strokes and on-time in ticks
  logic [1:0]  hm [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  int          dl [4] = '{0, 2, 2, 2};
  int          ho [4] = '{10, 5, 10, 10};
  localparam logic [66:0] CFG_DEF = {1'b0, 14'h0, 14'h270f, 14'h0064, 14'h0003, 8'h3c, 2'h0};
  localparam logic [66:0] CFG_CLA = {1'b0, 14'h270f, 14'h270f, 14'h2706, 14'h0003, 8'h01, 2'h1};
  cpom_top #(.TICK_CYC(TICK)) uut (.i_clk, .i_resetn, .i_cfg_load, .i_cfg_mode_pfm,
    .i_cfg_range_lo, .i_cfg_range_hi, .i_cfg_cycle, .i_cfg_min_on, .i_cfg_max_freq,
    .i_cfg_hold_mode, .i_source, .i_hold, .i_hold_fixed, .o_pulse, .o_mode_pfm,
    .o_range_lo, .o_range_hi, .o_cycle, .o_min_on, .o_max_freq, .o_hold_mode);
  cpom_pump_model pump (.i_clk, .i_drive(o_pulse), .o_strokes(strokes), .o_on_cyc(on_cyc),
    .o_period_cyc(period_cyc));
  task automatic load(input logic m, input logic [13:0] lo, hi, cy, mn, input logic [7:0] f,
    input logic [1:0] h);
    @(negedge i_clk);
    {i_cfg_mode_pfm, i_cfg_range_lo, i_cfg_range_hi, i_cfg_cycle} = {m, lo, hi, cy};
    {i_cfg_min_on, i_cfg_max_freq, i_cfg_hold_mode, i_cfg_load} = {mn, f, h, 1'b1};
    @(negedge i_clk);
    i_cfg_load = 1'b0;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic check_cfg(input logic [66:0] e, input string m);
    @(negedge i_clk);
    check_count++;
    if ({o_mode_pfm, o_range_lo, o_range_hi, o_cycle, o_min_on, o_max_freq, o_hold_mode}
      !== e) fail(m);
  endtask
  task automatic check_meas(input int got, input int e, input string m);
    check_count++;
    if (got != e) fail(m);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Free-running 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Watchdog: the tests need about 48 us, so 300 us means a hang
  initial
  begin
    #300us;
    fail("timeout");
    tally_and_finish();
  end
  // Config clamps land before the first 10 s period ends, so no huge period is latched
  initial
  begin
    {i_cfg_load, i_cfg_mode_pfm, i_cfg_range_lo, i_cfg_range_hi, i_cfg_cycle} = '0;
    {i_cfg_min_on, i_cfg_max_freq, i_cfg_hold_mode, i_source, i_hold, i_hold_fixed} = '0;
    i_resetn = 1'b0;
    wait_clk(12);
    i_resetn = 1'b1;
    check_cfg(CFG_DEF, "defaults");
    load(1'b0, 14'h3fff, 14'h0005, 14'h3fff, 14'h0001, 8'h00, 2'h1);
    check_cfg(CFG_CLA, "clamp a");
    load(1'b1, 14'h0000, 14'h0064, 14'h0001, 14'h0000, 8'hc8, 2'h0);
    check_cfg({1'b1, 14'h0, 14'h0064, 14'h0003, 14'h0003, 8'hb4, 2'h0}, "clamp b");
    $display("test config done");
    // Offset range 10..110 so the lower bound really shifts the position
    i_source = 14'h003c;
    load(1'b0, 14'h000a, 14'h006e, 14'h0014, 14'h0003, 8'h3c, 2'h0);
    wait_clk(1800);
    check_meas(on_cyc, 20 * (60 - 10) / (110 - 10) * TICK, "pwm on");
    check_meas(period_cyc, 20 * TICK, "pwm period");
    i_source = 14'h0014;
    wait_clk(400);
    s = strokes;
    wait_clk(600);
    check_meas(strokes - s, 0, "short pulse");
    $display("test pwm done");
    for (int k = 0; k < 2; k++)
    begin
      i_source = k ? 14'h0032 : 14'h0064;
      load(1'b1, 14'h0, 14'h0064, 14'h0014, 14'h0003, k ? 8'h3c : 8'hb4, 2'h0);
      s = strokes;
      wait_clk(1000);
      check_meas(on_cyc, k ? 50 : 10, "pfm on");
      check_meas(period_cyc, k ? 200 : 30, "pfm period");
      check_meas(strokes - s >= (k ? 3 : 20), 1, "pfm train");
    end
    $display("test pfm done");
    i_source = 14'h0032;
    i_hold_fixed = 14'h0019;
    for (int k = 0; k < 4; k++)
    begin
      load(1'b0, 14'h0, 14'h0064, 14'h0014, 14'h0003, 8'h3c, hm[k]);
      wait_clk(400);
      i_hold = 1'b1;
      wait_clk(400);
      s = strokes;
      wait_clk(400);
      check_meas(strokes - s, dl[k], "hold");
      check_meas(on_cyc, ho[k] * TICK, "hold on");
      i_hold = 1'b0;
    end
    $display("test hold done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
